// ### logic/rxa_pkg.sv
// constants, types and register map of the receive lock and word aligner
package rxa_pkg;
    // ==================================================
    // widths
    localparam int DW = 20;
    localparam int HW = 32;
    localparam logic [4:0] WL_8 = 5'h08;
    localparam logic [4:0] WL_10 = 5'h0A;
    localparam logic [4:0] WL_16 = 5'h10;
    localparam logic [4:0] WL_20 = 5'h14;
    localparam logic [5:0] PL_32 = 6'h20;
    localparam logic [5:0] PL_20 = 6'h14;
    localparam logic [5:0] PL_16 = 6'h10;
    localparam logic [5:0] PL_10 = 6'h0A;
    // ==================================================
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PATTERN = 8'h04;
    localparam logic [7:0] REG_PATLEN = 8'h08;
    localparam logic [7:0] REG_RLVLIM = 8'h0C;
    localparam logic [7:0] REG_FREQ = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    // ==================================================
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CPL_BIT = 2;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_SONET4_BIT = 4;
    localparam int CTRL_WSEL_LSB = 5;
    localparam int FREQ_TOL_LSB = 16;
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SONET = 2'h2;
    // ==================================================
    // reset values
    localparam logic [6:0] CTRL_RST = 7'h20;
    localparam logic [31:0] PATTERN_RST = 32'h0000_017C;
    localparam logic [5:0] PATLEN_RST = 6'h0A;
    localparam logic [9:0] RLVLIM_RST = 10'h0A0;
    localparam logic [15:0] FREQ_EXP_RST = 16'h0400;
    localparam logic [15:0] FREQ_TOL_RST = 16'h0001;
    // ==================================================
    // patterns and limits
    localparam logic [9:0] COMMA_K285 = 10'h17C;
    localparam logic [7:0] SONET_A1 = 8'hF6;
    localparam logic [7:0] SONET_A2 = 8'h28;
    localparam logic [9:0] RLV_MAX_8 = 10'h080;
    localparam logic [9:0] RLV_MAX_10 = 10'h0A0;
    localparam logic [9:0] RLV_MAX_16 = 10'h200;
    localparam logic [9:0] RLV_MAX_20 = 10'h280;
    localparam logic [1:0] RLV_MIN_PULSE = 2'h2;
    localparam logic [2:0] ACQ_COMMAS = 3'h3;
    localparam logic [2:0] LOSS_ERRS = 3'h4;
    // ==================================================
    // types
    typedef enum logic [1:0] {LOCK_REF = 2'b01, LOCK_DATA = 2'b10} rxa_lock_t;
    typedef enum logic [2:0] {SY_LOSS = 3'b001, SY_ACQ = 3'b010, SY_SYNC = 3'b100} rxa_sync_t;
    typedef struct packed {
        logic valid;
        logic [DW-1:0] data;
    } rxa_word_t;
endpackage

// ### logic/rxa_aligner.sv
// receive clock lock mode control, deserializer, word aligner and run-length check
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module rxa_aligner
    import rxa_pkg::*;
#(
    parameter int FREQ_WIN = 1024
) (
    // clock and reset (mclk is the recovered receive clock)
    input wire logic mclk,
    input wire logic nrst,
    // line side pins
    input wire logic serialIn,
    input wire logic refClkIn,
    input wire logic pllLockRaw,
    // fabric controls
    input wire logic lockToData,
    input wire logic lockToRef,
    input wire logic enaAlign,
    input wire logic codeErr,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // fabric outputs
    output rxa_word_t rxWord,
    output logic syncStatus,
    output logic patternDetect,
    output logic runLenViol,
    output logic freqLocked,
    output logic pllLocked
);
    // ==================================================
    // helpers
    function automatic logic [31:0] maskOf(input logic [5:0] n);
        maskOf = (n >= PL_32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << n) - 32'h0000_0001);
    endfunction

    // last n received bits, earliest in bit 0
    function automatic logic [31:0] lastBits(input logic [31:0] h, input logic [5:0] n);
        lastBits = (h >> (7'h20 - {1'b0, n})) & maskOf(n);
    endfunction

    function automatic logic [4:0] wordLen(input logic [1:0] sel);
        case (sel)
            2'h0: wordLen = WL_8;
            2'h1: wordLen = WL_10;
            2'h2: wordLen = WL_16;
            default: wordLen = WL_20;
        endcase
    endfunction

    // upper word of a pattern arrives first, so it goes to the low half
    function automatic logic [31:0] wordOrder(input logic [31:0] p, input logic [5:0] n);
        case (n)
            PL_32: wordOrder = {p[15:0], p[31:16]};
            PL_20: wordOrder = {12'h000, p[9:0], p[19:10]};
            PL_16: wordOrder = {16'h0000, p[7:0], p[15:8]};
            default: wordOrder = p;
        endcase
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = b[7-i];
        end
    endfunction

    // ==================================================
    // pin synchronisers
    logic serMeta_q, serSync_q, refMeta_q, refSync_q, refPrev_q, pllMeta_q, pllSync_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            serMeta_q <= 1'b0;
            serSync_q <= 1'b0;
            refMeta_q <= 1'b0;
            refSync_q <= 1'b0;
            refPrev_q <= 1'b0;
            pllMeta_q <= 1'b0;
            pllSync_q <= 1'b0;
        end else begin
            serMeta_q <= serialIn;
            serSync_q <= serMeta_q;
            refMeta_q <= refClkIn;
            refSync_q <= refMeta_q;
            refPrev_q <= refSync_q;
            pllMeta_q <= pllLockRaw;
            pllSync_q <= pllMeta_q;
        end
    end

    // ==================================================
    // registers
    logic [6:0] ctrl_q;
    logic [31:0] pattern_q;
    logic [5:0] patLen_q;
    logic [9:0] rlvLim_q;
    logic [15:0] freqExp_q, freqTol_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            pattern_q <= PATTERN_RST;
            patLen_q <= PATLEN_RST;
            rlvLim_q <= RLVLIM_RST;
            freqExp_q <= FREQ_EXP_RST;
            freqTol_q <= FREQ_TOL_RST;
        end else if (regWr) begin
            case (regAddr)
                REG_CTRL: ctrl_q <= regWrData[6:0];
                REG_PATTERN: pattern_q <= regWrData;
                REG_PATLEN: patLen_q <= regWrData[5:0];
                REG_RLVLIM: rlvLim_q <= regWrData[9:0];
                REG_FREQ: begin
                    freqExp_q <= regWrData[15:0];
                    freqTol_q <= regWrData[31:16];
                end
                default: ;
            endcase
        end
    end

    logic [1:0] mode, wsel;
    logic cplEn, edgeMode, sonet4;
    assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
    assign cplEn = ctrl_q[CTRL_CPL_BIT];
    assign edgeMode = ctrl_q[CTRL_EDGE_BIT];
    assign sonet4 = ctrl_q[CTRL_SONET4_BIT];
    assign wsel = ctrl_q[CTRL_WSEL_LSB +: 2];

    // ==================================================
    // reference frequency check
    logic [31:0] winCnt_q;
    logic [15:0] refEdges_q;
    logic freqOk_q;
    logic [15:0] freqDiff;
    assign freqDiff = (refEdges_q > freqExp_q) ? refEdges_q - freqExp_q : freqExp_q - refEdges_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            winCnt_q <= 32'h0000_0000;
            refEdges_q <= 16'h0000;
            freqOk_q <= 1'b0;
        end else if (winCnt_q == 32'(FREQ_WIN - 1)) begin
            winCnt_q <= 32'h0000_0000;
            refEdges_q <= 16'h0000;
            freqOk_q <= (freqDiff <= freqTol_q);
        end else begin
            winCnt_q <= winCnt_q + 32'h0000_0001;
            if (refSync_q && !refPrev_q && refEdges_q != 16'hFFFF) begin
                refEdges_q <= refEdges_q + 16'h0001;
            end
        end
    end

    // ==================================================
    // lock mode selection
    rxa_lock_t lockSt_q, lockSt_d;
    always_comb begin
        lockSt_d = lockSt_q;
        if (lockToData) begin
            lockSt_d = LOCK_DATA;
        end else if (lockToRef) begin
            lockSt_d = LOCK_REF;
        end else begin
            // both low, also when left tied off
            case (lockSt_q)
                LOCK_REF: if (pllSync_q && freqOk_q) lockSt_d = LOCK_DATA;
                LOCK_DATA: if (!freqOk_q) lockSt_d = LOCK_REF;
                default: lockSt_d = LOCK_REF;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lockSt_q <= LOCK_REF;
            freqLocked <= 1'b0;
            pllLocked <= 1'b0;
        end else begin
            lockSt_q <= lockSt_d;
            freqLocked <= (lockSt_d == LOCK_DATA);
            pllLocked <= pllSync_q;
        end
    end

    // ==================================================
    // pattern match on the bit history (recovered clock domain)
    logic [31:0] hist_q, histNext;
    logic [31:0] effPat, tail;
    logic [5:0] effLen, phase6;
    logic effCpl, match;
    assign histNext = {serSync_q, hist_q[31:1]};

    always_comb begin
        case (mode)
            MODE_SYNC: begin
                effPat = {22'h000000, COMMA_K285};
                effLen = PL_10;
                effCpl = 1'b1;
            end
            MODE_SONET: begin
                effPat = sonet4 ? {rev8(SONET_A2), rev8(SONET_A2), rev8(SONET_A1), rev8(SONET_A1)}
                                : {16'h0000, rev8(SONET_A2), rev8(SONET_A1)};
                effLen = sonet4 ? PL_32 : PL_16;
                effCpl = 1'b0;
            end
            default: begin
                effPat = wordOrder(pattern_q, patLen_q) & maskOf(patLen_q);
                effLen = patLen_q;
                effCpl = cplEn;
            end
        endcase
    end

    // one bit per clock, so the earliest match is always seen first
    assign tail = lastBits(histNext, effLen);
    assign match = (tail == effPat) || (effCpl && tail == (~effPat & maskOf(effLen)));

    // ==================================================
    // word boundary
    logic [4:0] wl, cnt_q, newCnt, curPhase, phase;
    logic onBoundary, relock, wordDone, enaPrev_q, enaRise, search_q;
    logic [31:0] wordBits;
    assign wordBits = lastBits(histNext, {1'b0, wl});
    assign wl = wordLen(wsel);
    assign newCnt = cnt_q + 5'h01;
    assign phase6 = effLen % {1'b0, wl};
    assign phase = phase6[4:0];
    assign curPhase = (newCnt == wl) ? 5'h00 : newCnt;
    assign onBoundary = (curPhase == phase);
    assign enaRise = enaAlign && !enaPrev_q;

    rxa_sync_t syncSt_q, syncSt_d;
    always_comb begin
        if (mode == MODE_SYNC) begin
            relock = match && !onBoundary && syncSt_q != SY_SYNC;
        end else if (edgeMode) begin
            relock = search_q && match;
        end else begin
            relock = enaAlign && match && !onBoundary;
        end
    end
    assign wordDone = relock ? (phase == 5'h00) : (newCnt == wl);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hist_q <= 32'h0000_0000;
            cnt_q <= 5'h00;
            rxWord <= '0;
        end else begin
            hist_q <= histNext;
            // pattern's first bit becomes the word's lsb
            cnt_q <= relock ? phase : ((newCnt == wl) ? 5'h00 : newCnt);
            rxWord.valid <= wordDone;
            if (wordDone) begin
                rxWord.data <= wordBits[DW-1:0];
            end
        end
    end

    // ==================================================
    // synchronisation state machine (sync mode only, held in loss otherwise)
    logic [2:0] good_q, err_q;
    always_comb begin
        syncSt_d = syncSt_q;
        case (syncSt_q)
            SY_LOSS: if (match) syncSt_d = SY_ACQ;
            SY_ACQ: begin
                if (codeErr) syncSt_d = SY_LOSS;
                else if (match && onBoundary && good_q + 3'h1 >= ACQ_COMMAS) syncSt_d = SY_SYNC;
            end
            SY_SYNC: if (codeErr && err_q + 3'h1 >= LOSS_ERRS) syncSt_d = SY_LOSS;
            default: syncSt_d = SY_LOSS;
        endcase
        if (mode != MODE_SYNC) syncSt_d = SY_LOSS;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            syncSt_q <= SY_LOSS;
            good_q <= 3'h0;
            err_q <= 3'h0;
        end else begin
            syncSt_q <= syncSt_d;
            if (syncSt_d != SY_ACQ) good_q <= 3'h0;
            else if (match && onBoundary) good_q <= good_q + 3'h1;
            if (syncSt_d != SY_SYNC) err_q <= 3'h0;
            else if (codeErr) err_q <= err_q + 3'h1;
        end
    end

    // ==================================================
    // sync status and pattern detect
    logic syncStatus_d;
    always_comb begin
        if (mode == MODE_SYNC) begin
            syncStatus_d = (syncSt_d == SY_SYNC);
        end else if (edgeMode) begin
            // held until the next rising edge restarts the search
            syncStatus_d = enaRise ? 1'b0 : ((search_q && match) ? 1'b1 : syncStatus);
        end else if (enaAlign) begin
            syncStatus_d = match;
        end else begin
            syncStatus_d = match && !onBoundary;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            enaPrev_q <= 1'b0;
            search_q <= 1'b0;
            syncStatus <= 1'b0;
            patternDetect <= 1'b0;
        end else begin
            enaPrev_q <= enaAlign;
            if (enaRise) search_q <= 1'b1;
            else if (relock) search_q <= 1'b0;
            syncStatus <= syncStatus_d;
            patternDetect <= match && (relock || onBoundary);
        end
    end

    // ==================================================
    // run-length violation
    logic prevBit_q, viol;
    logic [9:0] run_q, runNext, rlvMax, rlvLimEff;
    logic [1:0] rlvHold_q;
    assign runNext = (serSync_q != prevBit_q) ? 10'h001 : ((run_q == 10'h3FF) ? run_q : run_q + 10'h001);
    always_comb begin
        case (wsel)
            2'h0: rlvMax = RLV_MAX_8;
            2'h1: rlvMax = RLV_MAX_10;
            2'h2: rlvMax = RLV_MAX_16;
            default: rlvMax = RLV_MAX_20;
        endcase
    end
    // limits above the width's maximum are clamped, not honoured
    assign rlvLimEff = (rlvLim_q > rlvMax) ? rlvMax : rlvLim_q;
    assign viol = (runNext > rlvLimEff);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prevBit_q <= 1'b0;
            run_q <= 10'h000;
            rlvHold_q <= 2'h0;
            runLenViol <= 1'b0;
        end else begin
            prevBit_q <= serSync_q;
            run_q <= runNext;
            rlvHold_q <= viol ? RLV_MIN_PULSE - 2'h1 : ((rlvHold_q != 2'h0) ? rlvHold_q - 2'h1 : 2'h0);
            runLenViol <= viol || (rlvHold_q != 2'h0);
        end
    end

    // ==================================================
    // register read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                REG_CTRL: regRdData <= {25'h0000000, ctrl_q};
                REG_PATTERN: regRdData <= pattern_q;
                REG_PATLEN: regRdData <= {26'h0000000, patLen_q};
                REG_RLVLIM: regRdData <= {22'h000000, rlvLim_q};
                REG_FREQ: regRdData <= {freqTol_q, freqExp_q};
                REG_STATUS: regRdData <= {24'h000000, syncSt_q, lockSt_q, freqOk_q,
                                          runLenViol, syncStatus};
                default: regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

    // ==================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_force_data: assert property (lockToData |=> freqLocked)
        else $error("data override did not select data lock");
    a_force_ref: assert property (!lockToData && lockToRef |=> !freqLocked)
        else $error("reference override did not select reference lock");
    a_auto_gate: assert property (!lockToData && !lockToRef && lockSt_q == LOCK_REF
        && !(pllSync_q && freqOk_q) |=> !freqLocked)
        else $error("auto mode left reference lock without frequency match");
    a_freq_state: assert property (freqLocked == (lockSt_q == LOCK_DATA))
        else $error("frequency lock flag disagrees with lock mode");
    a_pll_flag: assert property (pllLocked == $past(pllSync_q))
        else $error("pll lock flag does not follow pll lock");
    a_detect_cause: assert property (patternDetect |-> $past(match))
        else $error("pattern detect without a pattern");
    a_rlv_width: assert property ($rose(runLenViol) |=> runLenViol)
        else $error("run-length violation shorter than two cycles");
    a_edge_clear: assert property (mode != MODE_SYNC && edgeMode && enaRise |=> !syncStatus)
        else $error("rising enable did not clear sync status");
    a_manual_cause: assert property (mode != MODE_SYNC && !edgeMode && syncStatus
        |-> $past(match))
        else $error("manual sync status without a match");
endmodule

// ### test/rxa_fabric_model.sv
// fabric-side consumer model for the aligned receive words
`timescale 1ns/1ps
module rxa_fabric_model
    import rxa_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // aligned words from the aligner
    input wire rxa_word_t rxWord,
    // words taken so far
    output logic [15:0] wordCount
);
    // ==========
    // consumer
    // fabric never stalls the stream, it only takes whole words
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wordCount <= 16'h0000;
        end else if (rxWord.valid) begin
            wordCount <= wordCount + 16'h0001;
        end
    end
endmodule

// ### test/rx_clock_lock_and_word_aligner_tb_top.sv
// self-checking bench for the receive lock and word aligner
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module rx_clock_lock_and_word_aligner_tb_top;
    import rxa_pkg::*;
    // ==========
    // signals
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic serialIn = 1'b0;
    logic refClkIn = 1'b0;
    logic pllLockRaw = 1'b0;
    logic lockToData = 1'b0;
    logic lockToRef = 1'b0;
    logic enaAlign = 1'b0;
    logic codeErr = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData;
    rxa_word_t rxWord;
    logic syncStatus, patternDetect, runLenViol, freqLocked, pllLocked;
    logic [15:0] wordCount;
    int failures = 0;
    int cmp_count = 0;
    int seed = 32'h2835;
    logic [11:0] wordQ[$];
    logic [31:0] rdQ[$];
    logic [11:0] ent;
    logic rdSeen = 1'b0;
    logic refRun = 1'b0;

    always #5 mclk = ~mclk;

    // reference pin toggles every cycle once enabled: one rising edge per two cycles
    always @(posedge mclk) begin
        if (refRun) begin
            refClkIn <= ~refClkIn;
        end
    end

    // ==========
    // instances
    // refClkIn stays low until refRun is set, so auto mode sees no in-tolerance count before then
    rxa_aligner #(.FREQ_WIN(64)) u_rxa_aligner (.mclk(mclk), .nrst(nrst),
        .serialIn(serialIn), .refClkIn(refClkIn), .pllLockRaw(pllLockRaw),
        .lockToData(lockToData), .lockToRef(lockToRef), .enaAlign(enaAlign),
        .codeErr(codeErr), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .rxWord(rxWord), .syncStatus(syncStatus),
        .patternDetect(patternDetect), .runLenViol(runLenViol),
        .freqLocked(freqLocked), .pllLocked(pllLocked));
    rxa_fabric_model u_rxa_fabric_model (.mclk(mclk), .nrst(nrst), .rxWord(rxWord),
        .wordCount(wordCount));

    // ==========
    // tasks
    task automatic finish_test;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
    endtask

    // first bit on the line is v[0]
    task automatic send_bits(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            serialIn <= v[i];
        end
    endtask

    task automatic wait_sig(input int sel, input int lim);
        int k;
        k = 0;
        while (((sel == 0) ? syncStatus : runLenViol) !== 1'b1 && k < lim) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (k >= lim) begin
            failures++;
            $display("unexpected timeout exp %0d got %0d", lim - 1, k);
            finish_test();
        end
    endtask

    // ==========
    // monitor: results are matched to the oldest note
    always @(posedge mclk) begin
        rdSeen <= regRd;
        if (rdSeen) begin
            `CHECK("regRdData", rdQ.pop_front(), regRdData)
        end
        if (patternDetect === 1'b1) begin
            if (wordQ.size() == 0) begin
                failures++;
                $display("unexpected patternDetect exp 0 got 1");
            end else begin
                ent = wordQ.pop_front();
                `CHECK("rxWord", ent[10:0], {rxWord.valid, rxWord.data[9:0]})
                if (ent[11]) `CHECK("syncStatus", 1'b1, syncStatus)
            end
        end
    end

    initial begin
        #900000;
        failures++;
        $display("unexpected runtime exp 0 got 1");
        finish_test();
    end

    // ==========
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        reg_rd(REG_CTRL, 32'h0000_0020);
        reg_rd(REG_PATTERN, 32'h0000_017C);
        reg_rd(REG_PATLEN, 32'h0000_000A);
        reg_rd(REG_RLVLIM, 32'h0000_00A0);
        reg_rd(REG_FREQ, 32'h0001_0400);
        reg_wr(8'h1C, 32'hFFFF_FFFF);
        reg_rd(8'h1C, 32'h0000_0000);
        // default comma is already lsb-first, no bit reversal needed
        // default comma, manual mode, enable held high
        @(posedge mclk);
        enaAlign <= 1'b1;
        wordQ.push_back({1'b1, 1'b1, 10'h17C});
        wordQ.push_back({1'b0, 1'b1, 10'h17C});
        send_bits(32'hAAAA_AAAA, 23);
        send_bits(32'h0000_017C, 10);
        send_bits(32'h0000_017C, 10);
        send_bits(32'hAAAA_AAAA, 20);
        `CHECK("wordCount", 1'b1, (wordCount > 16'h0002))
        // off-boundary comma with enable low gives a resync pulse only
        @(posedge mclk);
        enaAlign <= 1'b0;
        fork
            begin
                send_bits(32'hAAAA_AAAA, 3);
                send_bits(32'h0000_017C, 10);
            end
            wait_sig(0, 40);
        join
        send_bits(32'hAAAA_AAAA, 20);
        // run of 26 ones against a limit of 20
        reg_wr(REG_RLVLIM, 32'h0000_0014);
        fork
            send_bits(32'hFFFF_FFFF, 26);
            wait_sig(1, 40);
        join
        @(posedge mclk);
        #1;
        `CHECK("runLenViol", 1'b1, runLenViol)
        send_bits(32'hAAAA_AAAA, 10);
        // every override combination twice, pll lock random
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            lockToData <= i[0];
            lockToRef <= i[1];
            pllLockRaw <= 1'($random(seed));
            repeat (5) @(posedge mclk);
            #1;
            `CHECK("freqLocked", lockToData, freqLocked)
            `CHECK("pllLocked", pllLockRaw, pllLocked)
        end
        // auto mode with a reference near 32 edges per 64-cycle window
        @(posedge mclk);
        lockToData <= 1'b0;
        lockToRef <= 1'b0;
        pllLockRaw <= 1'b1;
        refRun <= 1'b1;
        reg_wr(REG_FREQ, 32'h0001_0020);
        repeat (300) @(posedge mclk);
        #1;
        `CHECK("freqLocked", 1'b1, freqLocked)
        finish_test();
    end
endmodule
